// ---- core/ifd_pkg.sv ----
// Constants, opcode patterns and types for the fetch and decode unit.
// Assumes a 21-bit byte-addressed program store and a 14-bit data space.
package ifd_pkg;

   // ***************************************************
   // Widths and reset values
   // ***************************************************
   localparam int PC_W = 21;
   localparam int DA_W = 14;
   localparam int BANK_W = 6;
   localparam int FSR_N = 3;
   localparam logic [20:0] PC_RST = 21'h0_0000;
   localparam logic [20:0] PC_STEP = 21'h0_0002;
   localparam logic [15:0] IR_RST = 16'h0000;
   localparam logic [7:0] W_RST = 8'h00;
   localparam logic [5:0] BANK_RST = 6'h00;
   localparam logic [13:0] FSR_RST = 14'h0000;

   // ***************************************************
   // Data space map
   // ***************************************************
   localparam logic [7:0] ACC_SPLIT = 8'h60;
   localparam logic [5:0] ACC_HI_BANK = 6'h3F;
   localparam logic [13:0] GPR_TOP = 14'h0FFF;
   localparam logic [13:0] SFR_BASE = 14'h3600;
   localparam logic [13:0] INDF_BASE = 14'h3FEF;
   localparam logic [13:0] PLUSW_BASE = 14'h3FEB;
   localparam logic [13:0] FSR_STRIDE = 14'h0008;

   // ***************************************************
   // Opcode patterns
   // ***************************************************
   localparam logic [3:0] CONT_PFX = 4'hF;
   localparam logic [7:0] OPC_GOTO = 8'hEF;
   localparam logic [6:0] OPC_CALL = 7'h76;
   localparam logic [7:0] OPC_PTRLD = 8'hEE;
   localparam logic [3:0] OPC_FF = 4'hC;
   localparam logic [11:0] OPC_FFL = 12'h006;
   localparam logic [15:0] OPC_SFL = 16'h0002;
   localparam logic [4:0] OPC_BRA = 5'h1A;
   localparam logic [9:0] OPC_MOVLB = 10'h004;
   localparam logic [7:0] OPC_MOVLW = 8'h0E;
   localparam logic [6:0] OPC_MOVWF = 7'h37;
   localparam logic [5:0] OPC_MOVF = 6'h14;
   localparam logic [6:0] OPC_TSTFSZ = 7'h33;

   typedef enum logic [1:0] {
      SEQ_FIRST = 2'b00,
      SEQ_WORD2 = 2'b01,
      SEQ_WORD3 = 2'b10
   } ifd_seq_type;

   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_GOTO = 3'b001,
      OP_CALL = 3'b010,
      OP_FF = 3'b011,
      OP_PTRLD = 3'b100,
      OP_FFL = 3'b101,
      OP_SFL = 3'b110
   } ifd_op_type;

endpackage

// ---- core/ifd_fetch_decode.sv ----
// Fetch and decode unit of an 8-bit core, one instruction word per clock.
// Assumes combinational program and data memories on clk_in: read data
// follows pm_addr_out and dm_addr_out within the same cycle.
//
// Summary of operation
// - Program memory addressed by byte, one/two/three-word instructions.
// - Low byte even address, high byte odd.
// - PC steps by two, bit zero zero.
// - Absolute target word address loads PC<20:1>.
// - Branch offset shifted left once before adding.
// - Decode two-word and three-word instruction classes.
// - Continuation words: prefix 1111, 12 literal bits.
// - In-sequence continuation supplies operand literal bits.
// - Lone continuation word executes as no-op.
// - Data addresses are 14 bits wide.
// - 64 banks of 256 bytes each.
// - Unimplemented data locations read as zero.
// - All banks reachable direct, indirect, indexed.
// - Access region bypasses the bank selector.
// - Banked address is selector joined with byte.
// - PC change discards prefetch, costs two cycles.
`timescale 1ns/1ps
`default_nettype none

module ifd_fetch_decode (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic [7:0] pm_lo_in,
   input wire logic [7:0] pm_hi_in,
   input wire logic [7:0] dm_rdata_in,
   output logic [ifd_pkg::PC_W-1:0] pm_addr_out,
   output logic [ifd_pkg::DA_W-1:0] dm_addr_out,
   output logic dm_rd_out,
   output logic dm_wr_out,
   output logic [7:0] dm_wdata_out,
   output logic [ifd_pkg::BANK_W-1:0] bank_sel_out,
   output logic [7:0] wreg_out,
   output logic call_out,
   output logic [ifd_pkg::PC_W-1:0] ret_addr_out,
   output logic cont_nop_out
);
   import ifd_pkg::*;

   // ***************************************************
   // State
   // ***************************************************
   logic [PC_W-1:0] pc_r;
   logic [PC_W-1:0] pc_nxt;
   logic [15:0] ir_r;
   logic ir_ok_r;
   logic flush;
   ifd_seq_type seq_r;
   ifd_seq_type seq_nxt;
   ifd_op_type op_r;
   ifd_op_type op_nxt;
   logic [7:0] lit_r;
   logic [7:0] lit_nxt;
   logic [1:0] dhi_r;
   logic [1:0] dhi_nxt;
   logic impl_r;
   logic ld_r;
   logic ld_nxt;
   logic tst_r;
   logic tst_nxt;
   logic [DA_W-1:0] da_nxt;
   logic rd_nxt;
   logic wr_nxt;
   logic [7:0] wd_nxt;
   logic [7:0] w_r;
   logic [7:0] w_nxt;
   logic [BANK_W-1:0] bank_r;
   logic [BANK_W-1:0] bank_nxt;
   logic [DA_W-1:0] fsr_r [FSR_N];
   logic fsr_we;
   logic [1:0] fsr_sel;
   logic [DA_W-1:0] fsr_val;
   logic call_nxt;
   logic [PC_W-1:0] ret_nxt;
   logic cnop_nxt;
   logic [7:0] rd_eff;
   logic [7:0] w_eff;
   logic skip_now;
   logic ex_first;
   logic is_cont;

   // ***************************************************
   // Address helpers
   // ***************************************************
   function automatic logic in_map(input logic [DA_W-1:0] a);
      in_map = (a <= GPR_TOP) || (a >= SFR_BASE);
   endfunction

   // Without the access bit the low bytes hit bank 0 and the rest the
   // top bank, so hot registers need no selector reload.
   function automatic logic [DA_W-1:0] file_addr(input logic [7:0] f,
                                                 input logic banked);
      if (banked) begin
         file_addr = {bank_r, f};
      end else if (f < ACC_SPLIT) begin
         file_addr = {BANK_RST, f};
      end else begin
         file_addr = {ACC_HI_BANK, f};
      end
   endfunction

   // Indirect and indexed windows swap in a pointer-based address.
   function automatic logic [DA_W-1:0] redirect(input logic [DA_W-1:0] a);
      logic [DA_W-1:0] r;
      r = a;
      for (int n = 0; n < FSR_N; n++) begin
         if (a == INDF_BASE - FSR_STRIDE * DA_W'(n)) begin
            r = fsr_r[n];
         end
         if (a == PLUSW_BASE - FSR_STRIDE * DA_W'(n)) begin
            r = fsr_r[n] + {{6{w_eff[7]}}, w_eff};
         end
      end
      redirect = r;
   endfunction

   // ***************************************************
   // Operand path
   // ***************************************************
   assign rd_eff = impl_r ? dm_rdata_in : 8'h00;
   assign w_eff = ld_r ? rd_eff : w_r;
   assign skip_now = tst_r && (rd_eff == 8'h00);
   assign ex_first = ir_ok_r && (seq_r == SEQ_FIRST) && !skip_now;
   assign is_cont = (ir_r[15:12] == CONT_PFX);

   // ***************************************************
   // Decode and execute
   // ***************************************************
   always_comb begin
      pc_nxt = pc_r + PC_STEP;
      flush = 1'b0;
      seq_nxt = SEQ_FIRST;
      op_nxt = op_r;
      lit_nxt = lit_r;
      dhi_nxt = dhi_r;
      da_nxt = dm_addr_out;
      rd_nxt = 1'b0;
      wr_nxt = 1'b0;
      wd_nxt = dm_wdata_out;
      w_nxt = w_eff;
      bank_nxt = bank_r;
      fsr_we = 1'b0;
      fsr_sel = 2'h0;
      fsr_val = fsr_r[0];
      ld_nxt = 1'b0;
      tst_nxt = 1'b0;
      call_nxt = 1'b0;
      ret_nxt = ret_addr_out;
      cnop_nxt = 1'b0;
      case (seq_r)
         SEQ_FIRST: begin
            if (ex_first) begin
               lit_nxt = ir_r[7:0];
               if (is_cont) begin
                  cnop_nxt = 1'b1;
               end else if (ir_r[15:8] == OPC_GOTO) begin
                  op_nxt = OP_GOTO;
                  seq_nxt = SEQ_WORD2;
               end else if (ir_r[15:9] == OPC_CALL) begin
                  op_nxt = OP_CALL;
                  seq_nxt = SEQ_WORD2;
               end else if (ir_r[15:8] == OPC_PTRLD && ir_r[7:6] == 2'h0) begin
                  op_nxt = OP_PTRLD;
                  seq_nxt = SEQ_WORD2;
               end else if (ir_r[15:12] == OPC_FF) begin
                  op_nxt = OP_FF;
                  seq_nxt = SEQ_WORD2;
                  rd_nxt = 1'b1;
                  da_nxt = redirect({2'h0, ir_r[11:0]});
               end else if (ir_r[15:4] == OPC_FFL) begin
                  op_nxt = OP_FFL;
                  seq_nxt = SEQ_WORD2;
               end else if (ir_r == OPC_SFL) begin
                  op_nxt = OP_SFL;
                  seq_nxt = SEQ_WORD2;
               end else if (ir_r[15:11] == OPC_BRA) begin
                  pc_nxt = pc_r + {{9{ir_r[10]}}, ir_r[10:0], 1'h0};
                  flush = 1'b1;
               end else if (ir_r[15:6] == OPC_MOVLB) begin
                  bank_nxt = ir_r[5:0];
               end else if (ir_r[15:8] == OPC_MOVLW) begin
                  w_nxt = ir_r[7:0];
               end else if (ir_r[15:9] == OPC_MOVWF) begin
                  da_nxt = redirect(file_addr(ir_r[7:0], ir_r[8]));
                  wr_nxt = in_map(da_nxt);
                  wd_nxt = w_eff;
               end else if (ir_r[15:10] == OPC_MOVF) begin
                  da_nxt = redirect(file_addr(ir_r[7:0], ir_r[8]));
                  rd_nxt = 1'b1;
                  ld_nxt = !ir_r[9];
               end else if (ir_r[15:9] == OPC_TSTFSZ) begin
                  da_nxt = redirect(file_addr(ir_r[7:0], ir_r[8]));
                  rd_nxt = 1'b1;
                  tst_nxt = 1'b1;
               end
            end
         end
         SEQ_WORD2: begin
            case (op_r)
               OP_GOTO, OP_CALL: begin
                  pc_nxt = {ir_r[11:0], lit_r, 1'h0};
                  flush = 1'b1;
                  call_nxt = (op_r == OP_CALL);
                  ret_nxt = (op_r == OP_CALL) ? pc_r : ret_addr_out;
               end
               OP_PTRLD: begin
                  fsr_we = 1'b1;
                  fsr_sel = lit_r[5:4];
                  fsr_val = {lit_r[3:0], ir_r[9:0]};
               end
               OP_FF: begin
                  da_nxt = redirect({2'h0, ir_r[11:0]});
                  wr_nxt = in_map(da_nxt);
                  wd_nxt = rd_eff;
               end
               OP_FFL: begin
                  da_nxt = redirect({lit_r[3:0], ir_r[11:2]});
                  rd_nxt = 1'b1;
                  dhi_nxt = ir_r[1:0];
                  seq_nxt = SEQ_WORD3;
               end
               OP_SFL: begin
                  da_nxt = redirect(fsr_r[2] + {7'h00, ir_r[8:2]});
                  rd_nxt = 1'b1;
                  dhi_nxt = ir_r[1:0];
                  seq_nxt = SEQ_WORD3;
               end
               default: begin
                  seq_nxt = SEQ_FIRST;
               end
            endcase
         end
         SEQ_WORD3: begin
            da_nxt = redirect({dhi_r, ir_r[11:0]});
            wr_nxt = in_map(da_nxt);
            wd_nxt = rd_eff;
         end
         default: begin
            seq_nxt = SEQ_FIRST;
         end
      endcase
   end

   // ***************************************************
   // Fetch pipeline
   // ***************************************************
   // The word fetched while a jump executes is dropped, so taken
   // branches cost one bubble but fetch never stalls.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pc_r <= PC_RST;
         ir_r <= IR_RST;
         ir_ok_r <= 1'b0;
      end else begin
         pc_r <= {pc_nxt[PC_W-1:1], 1'h0};
         ir_r <= {pm_hi_in, pm_lo_in};
         ir_ok_r <= !flush;
      end
   end

   assign pm_addr_out = pc_r;

   // ***************************************************
   // Multi-word sequencing
   // ***************************************************
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         seq_r <= SEQ_FIRST;
         op_r <= OP_NONE;
         lit_r <= 8'h00;
         dhi_r <= 2'h0;
      end else begin
         seq_r <= seq_nxt;
         op_r <= op_nxt;
         lit_r <= lit_nxt;
         dhi_r <= dhi_nxt;
      end
   end

   // ***************************************************
   // Data memory port
   // ***************************************************
   // Writes to holes are dropped here; reads of holes are zeroed on return.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         dm_addr_out <= FSR_RST;
         dm_rd_out <= 1'b0;
         dm_wr_out <= 1'b0;
         dm_wdata_out <= 8'h00;
         impl_r <= 1'b0;
         ld_r <= 1'b0;
         tst_r <= 1'b0;
      end else begin
         dm_addr_out <= da_nxt;
         dm_rd_out <= rd_nxt;
         dm_wr_out <= wr_nxt;
         dm_wdata_out <= wd_nxt;
         impl_r <= in_map(da_nxt);
         ld_r <= ld_nxt;
         tst_r <= tst_nxt;
      end
   end

   // ***************************************************
   // Core registers
   // ***************************************************
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         w_r <= W_RST;
         bank_r <= BANK_RST;
         call_out <= 1'b0;
         ret_addr_out <= PC_RST;
         cont_nop_out <= 1'b0;
      end else begin
         w_r <= w_nxt;
         bank_r <= bank_nxt;
         call_out <= call_nxt;
         ret_addr_out <= ret_nxt;
         cont_nop_out <= cnop_nxt;
      end
   end

   assign wreg_out = w_r;
   assign bank_sel_out = bank_r;

   genvar g;
   generate
      for (g = 0; g < FSR_N; g++) begin : g_fsr
         always_ff @(posedge clk_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
               fsr_r[g] <= FSR_RST;
            end else if (fsr_we && fsr_sel == 2'(g)) begin
               fsr_r[g] <= fsr_val;
            end
         end
      end
   endgenerate

endmodule // ifd_fetch_decode

`default_nettype wire

// ---- testbench/ifd_mem_model.sv ----
// Behavioural program and data memories facing the fetch and decode unit.
// Assumes the bench loads pm and dm through hierarchical writes while the unit is in reset.
`timescale 1ns/1ps
`default_nettype none
module ifd_mem_model (
   input wire logic clk_in,
   input wire logic [20:0] pm_addr_in,
   input wire logic [13:0] dm_addr_in,
   input wire logic dm_rd_in,
   input wire logic dm_wr_in,
   input wire logic [7:0] dm_wdata_in,
   output logic [7:0] pm_lo_out,
   output logic [7:0] pm_hi_out,
   output logic [7:0] dm_rdata_out
);
   logic [7:0] pm [0:255];
   logic [7:0] dm [0:16383];
   logic [7:0] junk_r = 8'hA5;
   wire logic impl = dm_addr_in <= 14'h0FFF || dm_addr_in >= 14'h3600;
   assign pm_lo_out = pm[{pm_addr_in[7:1], 1'b0}];
   assign pm_hi_out = pm[{pm_addr_in[7:1], 1'b1}];
   // An absent location drives a changing pattern, so only the unit itself can make it read as zero.
   assign dm_rdata_out = (impl && dm_rd_in) ? dm[dm_addr_in] : junk_r;
   always @(posedge clk_in) junk_r <= ~junk_r;
   always @(posedge clk_in) if (dm_wr_in) dm[dm_addr_in] <= dm_wdata_in;
endmodule // ifd_mem_model
`default_nettype wire

// ---- testbench/ifd_properties.sv ----
// Concurrent checks on the ports of the fetch and decode unit.
// Assumes one clock and the active-low asynchronous reset of the unit.
`timescale 1ns/1ps
`default_nettype none
module ifd_properties (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic [7:0] pm_lo_in,
   input wire logic [7:0] pm_hi_in,
   input wire logic [ifd_pkg::PC_W-1:0] pm_addr_out,
   input wire logic [ifd_pkg::DA_W-1:0] dm_addr_out,
   input wire logic dm_rd_out,
   input wire logic dm_wr_out,
   input wire logic call_out,
   input wire logic [ifd_pkg::PC_W-1:0] ret_addr_out,
   input wire logic cont_nop_out
);
   import ifd_pkg::*;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   // A word counts as executed only when the next fetch is one step on; otherwise it was a discarded bubble.
   pc_even_a: assert property (pm_addr_out[0] == 1'b0) else $error("fetch address odd");
   reset_start_a: assert property (!$past(arst_n_in, 2) && $past(arst_n_in) |-> pm_addr_out == PC_STEP)
      else $error("first fetch step after reset wrong");
   goto_load_a: assert property (pm_hi_in == 8'hEF ##1 pm_hi_in[7:4] == CONT_PFX
      && pm_addr_out == $past(pm_addr_out) + PC_STEP |-> ##2 (cont_nop_out
      || pm_addr_out == {$past({pm_hi_in[3:0], pm_lo_in}, 2), $past(pm_lo_in, 3), 1'b0}))
      else $error("jump target wrong");
   call_ret_a: assert property (pm_hi_in[7:1] == OPC_CALL ##1 pm_hi_in[7:4] == CONT_PFX
      && pm_addr_out == $past(pm_addr_out) + PC_STEP |-> ##2 (cont_nop_out
      || call_out && ret_addr_out == $past(pm_addr_out, 3) + 21'h0_0004)) else $error("call return wrong");
   bra_step_a: assert property (pm_hi_in[7:3] == OPC_BRA ##1 pm_addr_out == $past(pm_addr_out) + PC_STEP
      |-> ##1 (pm_addr_out == $past(pm_addr_out, 2) + PC_STEP + {{9{$past(pm_hi_in[2], 2)}},
      $past({pm_hi_in[2:0], pm_lo_in}, 2), 1'b0} || pm_addr_out == $past(pm_addr_out, 2) + 21'h0_0004))
      else $error("branch target wrong");
   file_move_a: assert property (pm_hi_in == 8'hC0 ##1 pm_hi_in == 8'hF0
      && pm_addr_out == $past(pm_addr_out) + PC_STEP |-> (##1 dm_rd_out && dm_addr_out == {6'h00,
      $past(pm_lo_in, 2)} ##1 dm_wr_out && dm_addr_out == {6'h00, $past(pm_lo_in, 2)}) or (##2 cont_nop_out))
      else $error("file to file move wrong");
   lone_nop_a: assert property (cont_nop_out |-> !dm_wr_out && !dm_rd_out && !call_out)
      else $error("lone continuation had an effect");
   wr_range_a: assert property (dm_wr_out |-> dm_addr_out <= GPR_TOP || dm_addr_out >= SFR_BASE)
      else $error("write to absent location");
endmodule // ifd_properties
bind ifd_fetch_decode ifd_properties chk (
   .clk_in(clk_in),
   .arst_n_in(arst_n_in),
   .pm_lo_in(pm_lo_in),
   .pm_hi_in(pm_hi_in),
   .pm_addr_out(pm_addr_out),
   .dm_addr_out(dm_addr_out),
   .dm_rd_out(dm_rd_out),
   .dm_wr_out(dm_wr_out),
   .call_out(call_out),
   .ret_addr_out(ret_addr_out),
   .cont_nop_out(cont_nop_out)
);
`default_nettype wire

// ---- testbench/tb_instruction_fetch_multiword_decode.sv ----
// Self-checking bench: runs short programs and judges memory and register results.
// Assumes the memory model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb_instruction_fetch_multiword_decode;
   import ifd_pkg::*;
   logic clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic [7:0] pm_lo;
   logic [7:0] pm_hi;
   logic [7:0] dm_rdata;
   logic [PC_W-1:0] pm_addr;
   logic [DA_W-1:0] dm_addr;
   logic dm_rd;
   logic dm_wr;
   logic [7:0] dm_wdata;
   logic [BANK_W-1:0] bank_sel;
   logic [7:0] wreg;
   logic call;
   logic [PC_W-1:0] ret_addr;
   logic cont_nop;
   int failures = 0;
   int n_checks = 0;
   int nops = 0;
   int calls = 0;
   always #50 clk_in = ~clk_in;
   // Pulse counters restart while the unit is held in reset, so each program is counted on its own.
   always @(posedge clk_in) begin
      if (!arst_n_in) begin
         nops <= 0;
         calls <= 0;
      end else begin
         if (cont_nop === 1'b1) nops <= nops + 1;
         if (call === 1'b1) calls <= calls + 1;
      end
   end
   ifd_fetch_decode dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .pm_lo_in(pm_lo), .pm_hi_in(pm_hi),
      .dm_rdata_in(dm_rdata), .pm_addr_out(pm_addr), .dm_addr_out(dm_addr), .dm_rd_out(dm_rd),
      .dm_wr_out(dm_wr), .dm_wdata_out(dm_wdata), .bank_sel_out(bank_sel), .wreg_out(wreg),
      .call_out(call), .ret_addr_out(ret_addr), .cont_nop_out(cont_nop));
   ifd_mem_model mem (.clk_in(clk_in), .pm_addr_in(pm_addr), .dm_addr_in(dm_addr), .dm_rd_in(dm_rd),
      .dm_wr_in(dm_wr), .dm_wdata_in(dm_wdata), .pm_lo_out(pm_lo), .pm_hi_out(pm_hi), .dm_rdata_out(dm_rdata));
   // ************************************
   // Shared tasks
   // ************************************
   task automatic chk(input logic [20:0] got, input logic [20:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Memories are reloaded only while the unit is held in reset, so no fetch sees a half-written program.
   task automatic start(input logic [15:0] p[$]);
      @(posedge clk_in);
      arst_n_in <= 1'b0;
      for (int i = 0; i < 16384; i++) mem.dm[i] = 8'h00;
      for (int i = 0; i < 256; i++) mem.pm[i] = 8'h00;
      foreach (p[i]) {mem.pm[2 * i + 1], mem.pm[2 * i]} = p[i];
   endtask
   task automatic run();
      repeat (4) @(posedge clk_in);
      chk(pm_addr, PC_RST);
      arst_n_in <= 1'b1;
      repeat (40) @(posedge clk_in);
      #10;
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ************************************
   // Scenarios
   // ************************************
   task automatic t_move_jump();
      start('{16'h0E55, 16'h6E20, 16'hC0A3, 16'hF056, 16'hEF08, 16'hF000, 16'h0E11, 16'h0E22, 16'h6E30, 16'hD7FF});
      mem.dm[14'h00A3] = 8'h3C;
      run();
      chk(21'(mem.dm[14'h0020]), 21'h0_0055);
      chk(21'(mem.dm[14'h0056]), 21'h0_003C);
      chk(21'(mem.dm[14'h0030]), 21'h0_0055);
      $display("move and jump test done");
   endtask
   task automatic t_call_branch();
      start('{16'hEC08, 16'hF000, 16'h0E99, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
         16'hD002, 16'h0E11, 16'h0E22, 16'h0E33, 16'h6E31, 16'hD7FF});
      run();
      chk(ret_addr, 21'h0_0004);
      chk(21'(calls), 21'h0_0001);
      chk(21'(wreg), 21'h0_0033);
      chk(21'(mem.dm[14'h0031]), 21'h0_0033);
      $display("call and branch test done");
   endtask
   task automatic t_skip_space();
      start('{16'h6640, 16'hC0A3, 16'hF057, 16'h0120, 16'h5110, 16'h6E41, 16'h0E77, 16'h6E70, 16'hEE00,
         16'hF123, 16'h50EF, 16'h6E42, 16'h0101, 16'h6F05, 16'h0060, 16'hF48C, 16'hF456, 16'hD7FF});
      mem.dm[14'h0057] = 8'hEE;
      mem.dm[14'h0041] = 8'hFF;
      mem.dm[14'h0123] = 8'h5A;
      run();
      chk(21'(mem.dm[14'h0057]), 21'h0_00EE);
      chk(21'(nops), 21'h0_0001);
      chk(21'(mem.dm[14'h0041]), 21'h0_0000);
      chk(21'(mem.dm[14'h3F70]), 21'h0_0077);
      chk(21'(mem.dm[14'h0042]), 21'h0_005A);
      chk(21'(mem.dm[14'h0105]), 21'h0_005A);
      chk(21'(bank_sel), 21'h0_0001);
      chk(21'(mem.dm[14'h0456]), 21'h0_005A);
      chk(21'(wreg), 21'h0_005A);
      $display("skip and data space test done");
   endtask
   // Pointer two is loaded, then used both for an indexed write and as the base of a three-word move.
   task automatic t_stack_move();
      start('{16'hEE20, 16'hF100, 16'h0E03, 16'h6EDB, 16'h0002, 16'hF014, 16'hF200, 16'hD7FF});
      mem.dm[14'h0105] = 8'hC3;
      run();
      chk(21'(mem.dm[14'h0103]), 21'h0_0003);
      chk(21'(mem.dm[14'h0200]), 21'h0_00C3);
      chk(21'(calls), 21'h0_0000);
      $display("stack move and indexed test done");
   endtask
   initial begin
      t_move_jump();
      t_call_branch();
      t_skip_space();
      t_stack_move();
      wrap_up();
   end
   initial begin
      #50000;
      failures++;
      wrap_up();
   end
endmodule // tb_instruction_fetch_multiword_decode
`default_nettype wire
